// File: uoc_pkg.sv
/*
 * shared constants for the on-chip unified cache: address split, geometry,
 * replacement bits, controller states.
 * assumes a 32-bit physical address and 32-bit data words.
 */
package uoc_pkg;

  // ********************************************************************
  // geometry
  // ********************************************************************
  localparam int UOC_ADDR_W   = 32;
  localparam int UOC_DATA_W   = 32;
  localparam int UOC_WAYS     = 4;
  localparam int UOC_SETS     = 128;
  localparam int UOC_LINE_B   = 16;
  localparam int UOC_OFS_W    = 4;
  localparam int UOC_IDX_W    = 7;
  localparam int UOC_TAG_W    = 21;
  localparam int UOC_WORDS    = 4;
  localparam int UOC_WSEL_W   = 2;
  localparam int UOC_BE_W     = 4;
  localparam int UOC_LRU_W    = 3;

  // ********************************************************************
  // address field positions
  // ********************************************************************
  localparam int UOC_IDX_LSB  = 4;
  localparam int UOC_IDX_MSB  = 10;
  localparam int UOC_TAG_LSB  = 11;
  localparam int UOC_TAG_MSB  = 31;
  localparam int UOC_WSEL_LSB = 2;
  localparam int UOC_WSEL_MSB = 3;

  // ********************************************************************
  // reset values and last line word index
  // ********************************************************************
  localparam logic [UOC_WAYS-1:0]  UOC_VALID_RST = 4'h0;
  localparam logic [UOC_LRU_W-1:0] UOC_LRU_RST   = 3'h0;
  localparam logic [1:0]           UOC_LAST_WORD = 2'h3;

  // ********************************************************************
  // controller states, gray along idle-fill-idle and idle-write-idle
  // ********************************************************************
  typedef enum logic [1:0] {
    UOC_IDLE  = 2'b00,
    UOC_FILL  = 2'b01,
    UOC_EVICT = 2'b11,
    UOC_WRITE = 2'b10
  } uoc_state_t;

endpackage : uoc_pkg

// File: uoc_tag_match.sv
/*
 * one way's tag comparator: hit when stored tag equals the probe tag and
 * the way is valid.
 * assumes stored tag and valid come straight from the array flops.
 */
`timescale 1ns/1ps

module uoc_tag_match
  import uoc_pkg::*;
#(
  parameter int TAG_W = UOC_TAG_W
) (
  input  wire logic [TAG_W-1:0] tag_stored,
  input  wire logic             valid,
  input  wire logic [TAG_W-1:0] tag_in,
  output logic                  hit
);

  assign hit = valid && (tag_stored == tag_in);

endmodule : uoc_tag_match

// File: uoc_cache.sv
/*
 * four-way set associative cache, 16-byte lines, pseudo-lru replacement,
 * read-miss line fills, write-through or optional write-back, external
 * single-line invalidation and full flush.
 * assumes the bus side answers each word with one bus_ack pulse and keeps
 * bus_ken valid with every ack of a read.
 */
`timescale 1ns/1ps

// Function
// - read hits served with no bus cycle
// - cacheable read miss fills 16-byte line
// - write-through hit updates line and memory
// - write-back hit updates line only, dirty
// - four ways of 128 sixteen-byte lines
// - offset 4, index 7, tag 21 bits
// - hit needs tag match and valid bit
// - three lru bits per set, updated
// - flush or reset clears all valid bits
// - fill prefers invalid way, else lru
// - partial line never marked valid
// - external invalidate clears matching line
// - flush invalidates everything at once
// - only read misses allocate lines
// - fill needs enable, ken, page, non-io
// - both bits clear: static ram mode
// - cache off, write-through on: no fills
// - both bits set: normal operation
// - valid lines still hit while fills off
// - write-through off: no write-through, no invalidate
// - all invalid means every read goes out
// - one new access per clock
module uoc_cache
  import uoc_pkg::*;
#(
  parameter int WAYS = UOC_WAYS,
  parameter int SETS = UOC_SETS
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  msr_cache_en,
  input  wire logic                  msr_wt_en,
  input  wire logic                  wb_policy,
  input  wire logic                  flush,
  input  wire logic                  req_valid,
  input  wire logic                  req_write,
  input  wire logic                  req_io,
  input  wire logic                  req_page_cacheable,
  input  wire logic [UOC_ADDR_W-1:0] req_addr,
  input  wire logic [UOC_DATA_W-1:0] req_wdata,
  input  wire logic [UOC_BE_W-1:0]   req_be,
  output logic                       req_ready,
  output logic                       rsp_valid,
  output logic [UOC_DATA_W-1:0]      rsp_rdata,
  output logic                       bus_req,
  output logic                       bus_write,
  output logic                       bus_line_fill,
  output logic [UOC_ADDR_W-1:0]      bus_addr,
  output logic [UOC_DATA_W-1:0]      bus_wdata,
  output logic [UOC_BE_W-1:0]        bus_be,
  input  wire logic                  bus_ack,
  input  wire logic                  bus_ken,
  input  wire logic [UOC_DATA_W-1:0] bus_rdata,
  input  wire logic                  inv_valid,
  input  wire logic [UOC_ADDR_W-1:0] inv_addr
);

  // ********************************************************************
  // storage
  // ********************************************************************
  logic [UOC_TAG_W-1:0]  tag_r   [WAYS][SETS];
  logic [UOC_DATA_W-1:0] data_r  [WAYS][SETS][UOC_WORDS];
  logic [WAYS-1:0]       valid_r [SETS];
  logic [WAYS-1:0]       dirty_r [SETS];
  logic [UOC_LRU_W-1:0]  lru_r   [SETS];

  uoc_state_t               state_r;
  logic [UOC_ADDR_W-1:0]    rq_addr_r;
  logic [UOC_DATA_W-1:0]    rq_wdata_r;
  logic [UOC_BE_W-1:0]      rq_be_r;
  logic                     fill_ok_r;
  logic [1:0]               vic_r;
  logic [UOC_WSEL_W-1:0]    cnt_r;
  logic [UOC_DATA_W-1:0]    fbuf_r [UOC_WORDS];
  logic                     rsp_valid_r;
  logic [UOC_DATA_W-1:0]    rsp_rdata_r;

  // ********************************************************************
  // address split and lookup
  // ********************************************************************
  logic [UOC_IDX_W-1:0]  req_idx, inv_idx, rq_idx;
  logic [UOC_TAG_W-1:0]  req_tag, inv_tag, rq_tag;
  logic [UOC_WSEL_W-1:0] req_wsel, rq_wsel, bus_wsel;
  logic [WAYS-1:0]       lk_hit, inv_hit;
  logic                  hit;
  logic [1:0]            hit_way, vic_way;
  logic                  accept, rd_fill_ok, inv_en, fill_done;

  assign req_idx  = req_addr[UOC_IDX_MSB:UOC_IDX_LSB];
  assign req_tag  = req_addr[UOC_TAG_MSB:UOC_TAG_LSB];
  assign req_wsel = req_addr[UOC_WSEL_MSB:UOC_WSEL_LSB];
  assign inv_idx  = inv_addr[UOC_IDX_MSB:UOC_IDX_LSB];
  assign inv_tag  = inv_addr[UOC_TAG_MSB:UOC_TAG_LSB];
  assign rq_idx   = rq_addr_r[UOC_IDX_MSB:UOC_IDX_LSB];
  assign rq_tag   = rq_addr_r[UOC_TAG_MSB:UOC_TAG_LSB];
  assign rq_wsel  = rq_addr_r[UOC_WSEL_MSB:UOC_WSEL_LSB];

  for (genvar gw = 0; gw < WAYS; gw++) begin : g_way
    uoc_tag_match #(.TAG_W(UOC_TAG_W)) u_lookup (
      .tag_stored (tag_r[gw][req_idx]),
      .valid      (valid_r[req_idx][gw]),
      .tag_in     (req_tag),
      .hit        (lk_hit[gw])
    );
    uoc_tag_match #(.TAG_W(UOC_TAG_W)) u_inval (
      .tag_stored (tag_r[gw][inv_idx]),
      .valid      (valid_r[inv_idx][gw]),
      .tag_in     (inv_tag),
      .hit        (inv_hit[gw])
    );
  end

  function automatic logic [1:0] uoc_enc(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : uoc_enc

  function automatic logic [UOC_DATA_W-1:0] uoc_merge(
    input logic [UOC_DATA_W-1:0] old_w,
    input logic [UOC_DATA_W-1:0] new_w,
    input logic [UOC_BE_W-1:0]   be
  );
    logic [UOC_DATA_W-1:0] r;
    r = old_w;
    for (int b = 0; b < UOC_BE_W; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction : uoc_merge

  // lru tree: bit0 set = pair 0/1 used last, bit1 set = way0 last,
  // bit2 set = way2 last
  function automatic logic [UOC_LRU_W-1:0] uoc_lru_upd(
    input logic [UOC_LRU_W-1:0] cur,
    input logic [1:0]           w
  );
    logic [UOC_LRU_W-1:0] r;
    r    = cur;
    r[0] = ~w[1];
    if (w[1]) begin
      r[2] = ~w[0];
    end else begin
      r[1] = ~w[0];
    end
    return r;
  endfunction : uoc_lru_upd

  assign hit     = |lk_hit;
  assign hit_way = uoc_enc(lk_hit);

  always_comb begin : vic_pick
    logic [UOC_LRU_W-1:0] l;
    l = lru_r[req_idx];
    if (~&valid_r[req_idx]) begin
      vic_way = uoc_enc(~valid_r[req_idx]);
    end else if (l[0]) begin
      vic_way = l[2] ? 2'h3 : 2'h2;
    end else begin
      vic_way = l[1] ? 2'h1 : 2'h0;
    end
  end

  // one lookup per cycle while idle; misses park the port
  assign req_ready  = (state_r == UOC_IDLE);
  assign accept     = ce && req_valid && req_ready;
  // fills need the enable bit, a cacheable page and a memory access
  assign rd_fill_ok = msr_cache_en && req_page_cacheable && !req_io;
  // write-through bit clear turns invalidation off
  assign inv_en     = ce && inv_valid && msr_wt_en;
  assign fill_done  = ce && (state_r == UOC_FILL) && bus_ack &&
                      fill_ok_r && bus_ken && (cnt_r == UOC_LAST_WORD);

  // ********************************************************************
  // controller
  // ********************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= UOC_IDLE;
      cnt_r   <= '0;
      vic_r   <= 2'h0;
      fill_ok_r <= 1'b0;
    end else if (ce) begin
      case (state_r)
        UOC_IDLE: begin
          cnt_r <= '0;
          if (accept) begin
            vic_r <= vic_way;
            if (req_write) begin
              // write-back or write-through off keeps hits local
              if (!hit || (msr_wt_en && !wb_policy)) begin
                state_r <= UOC_WRITE;
              end
            end else if (!hit) begin
              fill_ok_r <= rd_fill_ok;
              if (rd_fill_ok && wb_policy &&
                  valid_r[req_idx][vic_way] &&
                  dirty_r[req_idx][vic_way]) begin
                state_r <= UOC_EVICT;
              end else begin
                state_r <= UOC_FILL;
              end
            end
          end
        end
        UOC_EVICT: begin
          if (bus_ack) begin
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r == UOC_LAST_WORD) begin
              state_r <= UOC_FILL;
            end
          end
        end
        UOC_FILL: begin
          if (bus_ack) begin
            cnt_r <= cnt_r + 2'h1;
            // ken low on the first word turns the fill into one read
            if (!fill_ok_r || !bus_ken || cnt_r == UOC_LAST_WORD) begin
              state_r <= UOC_IDLE;
            end
          end
        end
        UOC_WRITE: begin
          if (bus_ack) begin
            state_r <= UOC_IDLE;
          end
        end
        default: state_r <= UOC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rq_addr_r  <= '0;
      rq_wdata_r <= '0;
      rq_be_r    <= '0;
    end else if (accept) begin
      rq_addr_r  <= req_addr;
      rq_wdata_r <= req_wdata;
      rq_be_r    <= req_be;
    end
  end

  // ********************************************************************
  // responses
  // ********************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= '0;
    end else if (ce) begin
      rsp_valid_r <= 1'b0;
      if (accept && hit && !req_write) begin
        rsp_valid_r <= 1'b1;
        rsp_rdata_r <= data_r[hit_way][req_idx][req_wsel];
      end else if (accept && req_write && hit &&
                   !(msr_wt_en && !wb_policy)) begin
        rsp_valid_r <= 1'b1;
      end else if (state_r == UOC_WRITE && bus_ack) begin
        rsp_valid_r <= 1'b1;
      end else if (state_r == UOC_FILL && bus_ack && cnt_r == '0) begin
        // requested word comes first, so answer without waiting
        rsp_valid_r <= 1'b1;
        rsp_rdata_r <= bus_rdata;
      end
    end
  end

  // ********************************************************************
  // bus side
  // ********************************************************************
  assign bus_wsel      = rq_wsel + cnt_r;
  assign bus_req       = (state_r != UOC_IDLE);
  assign bus_write     = (state_r == UOC_WRITE) || (state_r == UOC_EVICT);
  assign bus_line_fill = (state_r == UOC_FILL) && fill_ok_r;
  assign bus_be        = (state_r == UOC_WRITE) ? rq_be_r : 4'hf;
  assign bus_wdata     = (state_r == UOC_EVICT) ?
                         data_r[vic_r][rq_idx][cnt_r] : rq_wdata_r;
  always_comb begin
    if (state_r == UOC_EVICT) begin
      bus_addr = {tag_r[vic_r][rq_idx], rq_idx, cnt_r, 2'h0};
    end else if (state_r == UOC_FILL) begin
      bus_addr = {rq_addr_r[UOC_TAG_MSB:UOC_IDX_LSB], bus_wsel, 2'h0};
    end else begin
      bus_addr = rq_addr_r;
    end
  end
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rsp_rdata_r;

  // ********************************************************************
  // fill buffer and array data; line goes in only when complete
  // ********************************************************************
  always_ff @(posedge clk_sys) begin
    if (ce && state_r == UOC_FILL && bus_ack) begin
      fbuf_r[bus_wsel] <= bus_rdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (accept && req_write && hit) begin
      data_r[hit_way][req_idx][req_wsel] <=
        uoc_merge(data_r[hit_way][req_idx][req_wsel], req_wdata, req_be);
    end else if (fill_done) begin
      for (int w = 0; w < UOC_WORDS; w++) begin
        data_r[vic_r][rq_idx][w] <= (2'(w) == bus_wsel) ?
                                    bus_rdata : fbuf_r[w];
      end
      tag_r[vic_r][rq_idx] <= rq_tag;
    end
  end

  // ********************************************************************
  // valid, dirty, lru
  // ********************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      valid_r <= '{default: UOC_VALID_RST};
    end else if (ce) begin
      if (flush) begin
        valid_r <= '{default: UOC_VALID_RST};
      end else begin
        if (inv_en) begin
          valid_r[inv_idx] <= valid_r[inv_idx] & ~inv_hit;
        end
        // only read misses reach fill_done, and only on the last word
        if (fill_done) begin
          valid_r[rq_idx][vic_r] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dirty_r <= '{default: UOC_VALID_RST};
    end else if (ce) begin
      if (accept && req_write && hit && wb_policy) begin
        dirty_r[req_idx][hit_way] <= 1'b1;
      end else if (fill_done) begin
        dirty_r[rq_idx][vic_r] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lru_r <= '{default: UOC_LRU_RST};
    end else if (ce) begin
      if (accept && hit) begin
        lru_r[req_idx] <= uoc_lru_upd(lru_r[req_idx], hit_way);
      end else if (fill_done) begin
        lru_r[rq_idx] <= uoc_lru_upd(lru_r[rq_idx], vic_r);
      end
    end
  end

  // cache on with write-through off is for software to avoid

endmodule : uoc_cache

// File: uoc_cache_sva.sv
/*
 * port checker for the unified cache: bus framing, refusal, fill order,
 * write-through forwarding and fill gating.
 * assumes it is bound onto uoc_cache; one clock, async reset.
 */
`timescale 1ns/1ps

module uoc_cache_sva
  import uoc_pkg::*;
#(
  parameter int WAYS = UOC_WAYS,
  parameter int SETS = UOC_SETS
) (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  ce,
  input wire logic                  msr_cache_en,
  input wire logic                  msr_wt_en,
  input wire logic                  wb_policy,
  input wire logic                  req_valid,
  input wire logic                  req_write,
  input wire logic                  req_io,
  input wire logic                  req_page_cacheable,
  input wire logic [UOC_ADDR_W-1:0] req_addr,
  input wire logic [UOC_BE_W-1:0]   req_be,
  input wire logic                  req_ready,
  input wire logic                  rsp_valid,
  input wire logic                  bus_req,
  input wire logic                  bus_write,
  input wire logic                  bus_line_fill,
  input wire logic [UOC_ADDR_W-1:0] bus_addr,
  input wire logic [UOC_BE_W-1:0]   bus_be,
  input wire logic                  bus_ack
);
  // ********************************************************************
  // properties
  // ********************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic take;
  assign take = ce && req_valid && req_ready;

  chk_busy_refuse: assert property (bus_req |-> !req_ready)
    else $error("request port open during bus transfer");
  chk_fill_is_read: assert property (bus_line_fill |-> !bus_write)
    else $error("line fill marked as write");
  chk_read_be: assert property (bus_req && !bus_write
    |-> bus_be == 4'hf)
    else $error("read beat without all byte enables");
  chk_addr_hold: assert property (bus_req && !bus_ack && ce
    |=> bus_req && $stable(bus_addr))
    else $error("bus beat changed before ack");
  chk_fill_wrap: assert property (bus_line_fill && bus_ack && ce
    |=> !bus_req || (bus_addr[31:4] == $past(bus_addr[31:4])
    && bus_addr[3:2] == $past(bus_addr[3:2]) + 2'h1))
    else $error("fill beat left line or skipped a word");
  chk_fall_ack: assert property ($fell(bus_req) |-> $past(bus_ack))
    else $error("bus transfer closed without ack");
  chk_rsp_cause: assert property (rsp_valid && $past(ce)
    |-> $past(take) || $past(bus_ack && bus_req))
    else $error("answer without request or bus ack");
  chk_wt_fwd: assert property (take && req_write && msr_wt_en
    && !wb_policy |=> bus_req && bus_write
    && bus_addr[31:2] == $past(req_addr[31:2]) && bus_be == $past(req_be))
    else $error("write not forwarded to bus");
  chk_no_fill: assert property (take && !req_write && (req_io
    || !req_page_cacheable || !msr_cache_en) |=> !bus_line_fill)
    else $error("line fill for uncacheable read");
  chk_fill_go: assert property (take && !req_write && !req_io
    && req_page_cacheable && msr_cache_en
    |=> !bus_req || bus_line_fill || bus_write)
    else $error("cacheable read miss without fill");
  chk_wr_done: assert property (bus_req && bus_write && bus_ack && ce
    ##1 !bus_req |-> rsp_valid)
    else $error("write done without answer");

  cov_fill: cover property (bus_line_fill && bus_ack);
  cov_wt: cover property (bus_write && bus_ack);
  cov_b2b: cover property (rsp_valid ##1 rsp_valid);

endmodule : uoc_cache_sva

bind uoc_cache uoc_cache_sva #(.WAYS(WAYS), .SETS(SETS)) uoc_cache_sva_i (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .msr_cache_en(msr_cache_en),
  .msr_wt_en(msr_wt_en), .wb_policy(wb_policy), .req_valid(req_valid),
  .req_write(req_write), .req_io(req_io),
  .req_page_cacheable(req_page_cacheable), .req_addr(req_addr),
  .req_be(req_be), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .bus_req(bus_req), .bus_write(bus_write), .bus_line_fill(bus_line_fill),
  .bus_addr(bus_addr), .bus_be(bus_be), .bus_ack(bus_ack));

// File: uoc_bus_model.sv
/*
 * external bus partner: acks one word per beat, fast or with waits.
 * assumes one open transfer; word data is a fixed function of address.
 */
`timescale 1ns/1ps

module uoc_bus_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        ken_in,
  input  wire logic        bus_req,
  input  wire logic [31:0] bus_addr,
  output logic             bus_ack,
  output logic             bus_ken,
  output logic [31:0]      bus_rdata
);
  logic [1:0]  wait_r;
  logic        ack_r;
  logic [31:0] word;

  assign word = {bus_addr[31:2], 2'b00} ^ 32'h5a00_00a5;
  assign bus_ack = ack_r;
  // off the ack beat the lines carry junk, never the real word
  assign bus_rdata = ack_r ? word : ~word;
  assign bus_ken = ack_r ? ken_in : ~ken_in;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      wait_r <= 2'h0;
    end else begin
      ack_r <= 1'b0;
      if (bus_req && !ack_r) begin
        if (wait_r == (slow ? 2'h2 : 2'h0)) begin
          ack_r <= 1'b1;
          wait_r <= 2'h0;
        end else begin
          wait_r <= wait_r + 2'h1;
        end
      end
    end
  end
endmodule : uoc_bus_model

// File: tb_uoc_cache.sv
/*
 * self-checking bench: request sequences with expected data and bus words.
 * assumes uoc_cache, the bus partner model and the bound checker.
 */
`timescale 1ns/1ps

module tb_uoc_cache
  import uoc_pkg::*;
();
  logic clk_sys, rst, msr_cache_en, msr_wt_en, wb_policy, flush, slow;
  logic req_valid, req_write, req_io, req_page_cacheable, req_ready;
  logic rsp_valid, bus_req, bus_write, bus_line_fill, bus_ack, bus_ken;
  logic inv_valid, ken_in;
  logic [UOC_ADDR_W-1:0] req_addr, bus_addr, inv_addr;
  logic [UOC_DATA_W-1:0] req_wdata, rsp_rdata, bus_wdata, bus_rdata, wr_data;
  logic [UOC_BE_W-1:0]   req_be, bus_be;
  int failures, n_checks, n_acks;
  localparam logic [31:0] A = 32'h0000_1230;
  localparam logic [31:0] L = 32'h0000_3230;
  localparam logic [31:0] F = 32'h0000_0100;
  localparam logic [31:0] G = 32'h0000_0200;

  uoc_cache uoc_cache_i (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
    .msr_cache_en(msr_cache_en), .msr_wt_en(msr_wt_en),
    .wb_policy(wb_policy), .flush(flush), .req_valid(req_valid),
    .req_write(req_write), .req_io(req_io),
    .req_page_cacheable(req_page_cacheable), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_be(req_be), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus_req(bus_req),
    .bus_write(bus_write), .bus_line_fill(bus_line_fill),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_be(bus_be),
    .bus_ack(bus_ack), .bus_ken(bus_ken), .bus_rdata(bus_rdata),
    .inv_valid(inv_valid), .inv_addr(inv_addr));

  uoc_bus_model uoc_bus_model_i (.clk_sys(clk_sys), .rst(rst), .slow(slow),
    .ken_in(ken_in), .bus_req(bus_req), .bus_addr(bus_addr),
    .bus_ack(bus_ack), .bus_ken(bus_ken), .bus_rdata(bus_rdata));

  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic logic [31:0] mw(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'h5a00_00a5;
  endfunction : mw

  function automatic logic [31:0] ax(input int k);
    return A + {k[20:0], 11'h0};
  endfunction : ax

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one request; counts bus words until the port is free again
  task automatic op(input logic wr, input logic [31:0] a,
                    input logic [31:0] d, input logic [3:0] be,
                    input logic [31:0] acks, input logic [31:0] rd);
    int n0;
    int t;
    @(negedge clk_sys);
    n0 = n_acks;
    t = 0;
    req_valid = 1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_be = be;
    while (req_ready !== 1'b1 && t < 100) begin
      @(negedge clk_sys);
      t++;
    end
    @(negedge clk_sys);
    req_valid = 0;
    while (rsp_valid !== 1'b1 && t < 100) begin
      @(negedge clk_sys);
      t++;
    end
    if (!wr) chk("read data", rd, rsp_rdata);
    while (req_ready !== 1'b1 && t < 100) begin
      @(negedge clk_sys);
      t++;
    end
    chk("bus words", acks, 32'(n_acks - n0));
    chk("handshake stall", 32'h0, 32'(t / 100));
  endtask : op

  task automatic pulse(input logic fl, input logic [31:0] a);
    @(negedge clk_sys);
    flush = fl;
    inv_valid = !fl;
    inv_addr = a;
    @(negedge clk_sys);
    flush = 0;
    inv_valid = 0;
  endtask : pulse

  task automatic mode(input logic [2:0] m);
    @(negedge clk_sys);
    {msr_cache_en, msr_wt_en, wb_policy} = m;
  endtask : mode

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  always @(posedge clk_sys) begin
    if (bus_req === 1'b1 && bus_ack === 1'b1) n_acks++;
    if (bus_write === 1'b1 && bus_ack === 1'b1) wr_data = bus_wdata;
  end

  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    $display("ERROR watchdog expected finish seen timeout");
    end_of_test();
  end

  // ********************************************************************
  // tests
  // ********************************************************************
  initial begin
    {rst, flush, slow, req_valid, req_write, req_io, inv_valid} = 7'h0;
    rst = 1;
    {req_page_cacheable, ken_in} = 2'b11;
    {msr_cache_en, msr_wt_en, wb_policy} = 3'b110;
    {req_addr, req_wdata, inv_addr, req_be} = '0;
    {failures, n_checks, n_acks} = '0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 0;
    op(0, A, 0, 4'hf, 4, mw(A));
    op(0, A + 4, 0, 4'hf, 0, mw(A + 4));
    @(negedge clk_sys);
    req_valid = 1;
    req_addr = A + 8;
    @(negedge clk_sys);
    req_addr = A + 12;
    chk("first hit", mw(A + 8), rsp_rdata);
    @(negedge clk_sys);
    req_valid = 0;
    chk("second hit", mw(A + 12), rsp_rdata);
    $display("test fill_and_hit finished");
    for (int k = 1; k < 4; k++) op(0, ax(k), 0, 4'hf, 4, mw(ax(k)));
    for (int k = 0; k < 4; k++) op(0, ax(k), 0, 4'hf, 0, mw(ax(k)));
    op(0, ax(3), 0, 4'hf, 0, mw(ax(3)));
    op(0, L, 0, 4'hf, 4, mw(L));
    op(0, ax(3), 0, 4'hf, 0, mw(ax(3)));
    $display("test replacement finished");
    slow = 1;
    op(1, L + 4, 32'h1111_2222, 4'h3, 1, 0);
    chk("bus write data", 32'h1111_2222, wr_data);
    op(0, L + 4, 0, 4'hf, 0, (mw(L + 4) & 32'hffff_0000) | 32'h2222);
    op(1, 32'h5000, 32'h3333_4444, 4'hf, 1, 0);
    op(0, 32'h5000, 0, 4'hf, 4, mw(32'h5000));
    pulse(0, L + 8);
    op(0, L, 0, 4'hf, 4, mw(L));
    $display("test write_and_invalidate finished");
    for (int i = 0; i < 3; i++) begin
      req_io = (i == 0);
      req_page_cacheable = (i != 1);
      ken_in = (i != 2);
      repeat (2) op(0, 32'h6000 + 32'(i * 16), 0, 4'hf, 1,
                    mw(32'h6000 + 32'(i * 16)));
    end
    {req_io, req_page_cacheable, ken_in} = 3'b011;
    $display("test uncacheable finished");
    mode(3'b010);
    op(0, L, 0, 4'hf, 0, mw(L));
    repeat (2) op(0, 32'h7000, 0, 4'hf, 1, mw(32'h7000));
    op(1, L, 32'h5555_6666, 4'hf, 1, 0);
    chk("bus write data", 32'h5555_6666, wr_data);
    pulse(0, L);
    op(0, L, 0, 4'hf, 1, mw(L));
    mode(3'b110);
    op(0, F, 0, 4'hf, 4, mw(F));
    mode(3'b000);
    op(1, F, 32'hdead_beef, 4'hf, 0, 0);
    pulse(0, F);
    op(0, F, 0, 4'hf, 0, 32'hdead_beef);
    op(1, 32'h7100, 32'h7777_8888, 4'hf, 1, 0);
    chk("bus write data", 32'h7777_8888, wr_data);
    $display("test configurations finished");
    mode(3'b110);
    pulse(1, 0);
    op(0, F, 0, 4'hf, 4, mw(F));
    mode(3'b111);
    op(0, G, 0, 4'hf, 4, mw(G));
    op(1, G + 12, 32'h0bad_cafe, 4'hf, 0, 0);
    op(0, G + 12, 0, 4'hf, 0, 32'h0bad_cafe);
    // fifth tag in the set pushes the dirty line out before its fill
    for (int k = 1; k < 5; k++) begin
      op(0, G + {k[20:0], 11'h0}, 0, 4'hf, k > 3 ? 8 : 4,
         mw(G + {k[20:0], 11'h0}));
    end
    chk("evicted word", 32'h0bad_cafe, wr_data);
    $display("test flush_and_write_back finished");
    end_of_test();
  end
endmodule : tb_uoc_cache
